/* File: aif_pkg.sv */
// Package of constants and carrier types for the auxiliary event block
package aif_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_AUX = 6'h0b; // Auxiliary event flags
  localparam logic [5:0] IDX_FIFO1 = 6'h0c; // Unread byte count
  localparam logic [5:0] IDX_FIFO2 = 6'h0d; // FIFO errors and partial byte
  localparam logic [5:0] IDX_IRQ_STAT = 6'h0e; // Sticky interrupt status
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0f; // Interrupt enable mask
  localparam logic [5:0] IDX_CMD = 6'h10; // Direct command strobes

  // Auxiliary flag bit positions
  localparam int AUX_DES = 7; // Deselect received
  localparam int AUX_FR = 6; // Framing error
  localparam int AUX_PAR = 5; // Parity error
  localparam int AUX_CRC = 4; // CRC error
  localparam int AUX_FIFO = 3; // FIFO overflow or underflow
  localparam int AUX_EEW = 2; // EEPROM write done
  localparam int AUX_EEF = 1; // EEPROM write failed
  localparam int AUX_EEA = 0; // EEPROM access aborted

  // Second FIFO status register bit positions
  localparam int F2_UNF = 6; // Underflow
  localparam int F2_OVR = 5; // Overflow
  localparam int F2_NCP = 4; // Last byte incomplete
  localparam int F2_LB_LSB = 1; // Low bit of last byte bit count
  localparam int F2_NPB = 0; // Missing parity bit

  // Command register bit positions
  localparam int CMD_DEFAULT = 0; // Set default
  localparam int CMD_CLEAR = 1; // Clear FIFO

  // Reset values and sizes
  localparam logic [7:0] RST_BYTE = 8'h00; // All three registers reset
  localparam logic [5:0] FIFO_DEPTH = 6'h20; // Bytes held by the FIFO
  localparam logic [31:0] RD_NONE = 32'h0000_0000; // Unmapped read data

  // Event pulses from the receiver and EEPROM controller
  typedef struct packed {
    logic deselect; // Deselect command received
    logic framing; // Framing error
    logic parity; // Parity error
    logic crc; // CRC error
    logic ee_done; // Host EEPROM write finished
    logic ee_fail; // Host EEPROM write refused
    logic ee_abort; // Host EEPROM access aborted
  } aif_evt_t;

  // FIFO traffic seen by the status logic
  typedef struct packed {
    logic push; // A byte enters the FIFO
    logic [2:0] bits; // Valid bits of that byte, 0 means full
    logic no_parity; // Pushed byte arrived without parity
    logic pop; // Host reads one byte out
  } aif_fifo_t;

endpackage : aif_pkg

/* File: aif_status.sv */
// Auxiliary event flags and FIFO status registers on a Wishbone slave
// Operation
// RL1 - Latch eight auxiliary events at fixed bits
// RL2 - Errored frames still stored, error flag raised
// RL3 - FIFO over/underflow sets auxiliary bit 3
// RL4 - Host EEPROM write success sets bit 2
// RL5 - Host EEPROM write refusal sets bit 1
// RL6 - EEPROM access abort sets bit 0
// RL7 - Auxiliary flags clear at reset, default command
// RL8 - Reading auxiliary register clears all flags
// RL9 - First FIFO status shows unread byte count
// RL10 - FIFO status clears on reset, default, clear
// RL11 - Underflow at bit 6, overflow at 5
// RL12 - Incomplete last byte sets bit 4
// RL13 - Last byte bit count in bits 3..1
// RL14 - Missing parity sets bit 0, framing error
// RL15 - Summary bit holds until auxiliary register read
// RL16 - Reserved bits read zero, ignore events
`timescale 1ns/1ns
`default_nettype none

module aif_status #(
  parameter int DW = 32 // Wishbone data width
) (
  input wire logic clk_i, // 10 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [DW-1:0] dat_i, // Wishbone write data
  output logic [DW-1:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire aif_pkg::aif_evt_t evt_i, // Event pulses
  input wire aif_pkg::aif_fifo_t fifo_i, // FIFO traffic pulses
  output logic aux_pending_o, // Main summary bit for auxiliary events
  output logic irq_o // Level interrupt
);

  // Word index of the current bus address
  function automatic logic [5:0] word_idx(input logic [7:0] a);
    word_idx = a[7:2];
  endfunction : word_idx

  // True when the bus address selects the given index
  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    hit = (word_idx(a) == idx);
  endfunction : hit

  logic req; // Request waiting for its single acknowledge
  logic rd_aux; // Read of the auxiliary register completes
  logic wr_lane0; // Write with the low byte lane selected
  logic cmd_default; // Set default command
  logic cmd_clear; // Clear FIFO command
  logic [7:0] aux_reg; // Auxiliary event flags
  logic [7:0] aux_next; // Next auxiliary flags
  logic [7:0] aux_set; // Events seen this cycle
  logic [5:0] cnt_reg; // Unread byte count
  logic [5:0] cnt_next; // Next byte count
  logic unf_reg; // Underflow flag
  logic ovr_reg; // Overflow flag
  logic ncp_reg; // Last byte incomplete
  logic [2:0] lb_reg; // Bits in last byte
  logic npb_reg; // Missing parity on last byte
  logic over_evt; // Push into a full FIFO
  logic under_evt; // Pop from an empty FIFO
  logic [7:0] fifo1_word; // First FIFO status as read
  logic [7:0] fifo2_word; // Second FIFO status as read
  logic [7:0] stat_reg; // Sticky interrupt status
  logic [7:0] mask_reg; // Interrupt mask, one enables

  // A request is answered once; ack falls in the following cycle
  assign req = cyc_i && stb_i && !ack_o;
  assign rd_aux = req && !we_i && hit(adr_i, aif_pkg::IDX_AUX);
  assign wr_lane0 = req && we_i && sel_i[0];
  assign cmd_default = wr_lane0 && hit(adr_i, aif_pkg::IDX_CMD)
                       && dat_i[aif_pkg::CMD_DEFAULT];
  assign cmd_clear = wr_lane0 && hit(adr_i, aif_pkg::IDX_CMD)
                     && dat_i[aif_pkg::CMD_CLEAR];

  // FIFO misuse is judged against the count before this cycle
  assign over_evt = fifo_i.push && !fifo_i.pop
                    && (cnt_reg == aif_pkg::FIFO_DEPTH);
  // A pop together with a push at empty hands the new byte straight out
  assign under_evt = fifo_i.pop && !fifo_i.push
                     && (cnt_reg == 6'h00); // RL11

  // Gather this cycle's events into the auxiliary layout
  always_comb
  begin
    aux_set = 8'h00;
    aux_set[aif_pkg::AUX_DES] = evt_i.deselect; // RL1
    // Missing parity is a framing error as well
    aux_set[aif_pkg::AUX_FR] = evt_i.framing
      || (fifo_i.push && fifo_i.no_parity); // RL14
    // Errors flag only; the bytes still go in through push
    aux_set[aif_pkg::AUX_PAR] = evt_i.parity; // RL2
    aux_set[aif_pkg::AUX_CRC] = evt_i.crc; // RL2
    aux_set[aif_pkg::AUX_FIFO] = over_evt || under_evt; // RL3
    aux_set[aif_pkg::AUX_EEW] = evt_i.ee_done; // RL4
    aux_set[aif_pkg::AUX_EEF] = evt_i.ee_fail; // RL5
    aux_set[aif_pkg::AUX_EEA] = evt_i.ee_abort; // RL6
  end

  // Read clears, but an event in the same cycle survives the clear
  always_comb
  begin
    aux_next = aux_reg;
    if (rd_aux || cmd_default)
    begin
      aux_next = aif_pkg::RST_BYTE; // RL7 RL8
    end
    aux_next = aux_next | aux_set;
  end

  // Auxiliary flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_reg <= aif_pkg::RST_BYTE; // RL7
    end
    else
    begin
      aux_reg <= aux_next; // RL1
    end
  end

  // Byte count; simultaneous push and pop leave it unchanged
  always_comb
  begin
    cnt_next = cnt_reg;
    if (fifo_i.push && !fifo_i.pop && !over_evt)
    begin
      cnt_next = cnt_reg + 6'h01;
    end
    else if (fifo_i.pop && !fifo_i.push && !under_evt)
    begin
      cnt_next = cnt_reg - 6'h01;
    end
  end

  // Count register; a push into an empty FIFO with a pop is not underflow
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cmd_default || cmd_clear)
    begin
      cnt_reg <= 6'h00; // RL10
    end
    else
    begin
      cnt_reg <= cnt_next; // RL9
    end
  end

  // Sticky FIFO error flags, held until a clear or default command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unf_reg <= 1'b0; // RL10
      ovr_reg <= 1'b0;
    end
    else if (cmd_default || cmd_clear)
    begin
      // A misuse in the clearing cycle is still reported: set wins
      unf_reg <= under_evt; // RL10 RL11
      ovr_reg <= over_evt;
    end
    else
    begin
      unf_reg <= unf_reg || under_evt; // RL11
      ovr_reg <= ovr_reg || over_evt; // RL11
    end
  end

  // Last byte description follows every accepted push
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cmd_default || cmd_clear)
    begin
      ncp_reg <= 1'b0; // RL10
      lb_reg <= 3'h0;
      npb_reg <= 1'b0;
    end
    else if (fifo_i.push && !over_evt)
    begin
      ncp_reg <= (fifo_i.bits != 3'h0); // RL12
      lb_reg <= fifo_i.bits; // RL13
      npb_reg <= fifo_i.no_parity; // RL14
    end
  end

  // Status words; reserved bits are hard zeros
  assign fifo1_word = {2'b00, cnt_reg}; // RL9 RL16
  assign fifo2_word = {1'b0, unf_reg, ovr_reg, ncp_reg,
                       lb_reg, npb_reg}; // RL16

  // Interrupt status: same layout as the flags, write one to clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_reg <= aif_pkg::RST_BYTE;
    end
    else if (cmd_default)
    begin
      // Set wins over the default command, as for the flags
      stat_reg <= aux_set;
    end
    else if (wr_lane0 && hit(adr_i, aif_pkg::IDX_IRQ_STAT))
    begin
      stat_reg <= (stat_reg & ~dat_i[7:0]) | aux_set;
    end
    else
    begin
      stat_reg <= stat_reg | aux_set;
    end
  end

  // Interrupt mask, written by software
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cmd_default)
    begin
      mask_reg <= aif_pkg::RST_BYTE;
    end
    else if (wr_lane0 && hit(adr_i, aif_pkg::IDX_IRQ_MASK))
    begin
      mask_reg <= dat_i[7:0];
    end
  end

  // Outputs are registered; irq_o lags the status by one cycle, aux_pending_o is taken from aux_next and moves with the flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
      aux_pending_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(stat_reg & mask_reg);
      aux_pending_o <= |aux_next; // RL15
    end
  end

  // Bus answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= req;
      if (req && !we_i)
      begin
        case (word_idx(adr_i))
          aif_pkg::IDX_AUX: dat_o <= DW'(aux_reg);
          aif_pkg::IDX_FIFO1: dat_o <= DW'(fifo1_word);
          aif_pkg::IDX_FIFO2: dat_o <= DW'(fifo2_word);
          aif_pkg::IDX_IRQ_STAT: dat_o <= DW'(stat_reg);
          aif_pkg::IDX_IRQ_MASK: dat_o <= DW'(mask_reg);
          default: dat_o <= DW'(aif_pkg::RD_NONE);
        endcase
      end
      else
      begin
        dat_o <= '0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Deselect lands in bit 7 on the next edge
  des_flag_a: assert property (evt_i.deselect |=> aux_reg[7]) // RL1
    else $error("deselect not latched");

  // Parity error flagged on the next edge, with or without a push
  par_flag_a: assert property (evt_i.parity |=> aux_reg[5]) // RL2
    else $error("parity error not latched");

  // FIFO underflow shows in bit 3 and in the cause flag
  fifo_err_a: assert property (under_evt |=> aux_reg[3] && unf_reg) // RL3
    else $error("underflow not reported");

  // EEPROM events land in bits 2..0, each on its own
  ee_flags_a: assert property (evt_i.ee_done |=> aux_reg[2]) // RL4
    else $error("eeprom done not latched");

  ee_fail_a: assert property (evt_i.ee_fail |=> aux_reg[1]) // RL5
    else $error("eeprom failure not latched");

  ee_abort_a: assert property (evt_i.ee_abort |=> aux_reg[0]) // RL6
    else $error("eeprom abort not latched");

  // A quiet read leaves every flag cleared
  read_clear_a: assert property (rd_aux && aux_set == 8'h00
    |=> aux_reg == 8'h00) // RL8
    else $error("auxiliary read did not clear");

  // Default command clears flags and byte count
  dflt_clear_a: assert property (cmd_default && aux_set == 8'h00
    |=> aux_reg == 8'h00 && cnt_reg == 6'h00) // RL7
    else $error("default command did not clear");

  // Count never passes the FIFO depth
  cnt_range_a: assert property (cnt_reg <= 6'h20) // RL9
    else $error("byte count out of range");

  // Overflow sets bit 5 and bit 3 together
  ovr_flag_a: assert property (over_evt |=> ovr_reg && aux_reg[3]) // RL11
    else $error("overflow not reported");

  // Incomplete byte sets bit 4 with its count
  part_byte_a: assert property (fifo_i.push && !over_evt
    && fifo_i.bits == 3'h5 |=> ncp_reg && lb_reg == 3'h5) // RL13
    else $error("partial byte not reported");

  // Missing parity raises bit 0 and the framing flag
  no_par_a: assert property (fifo_i.push && !over_evt
    && fifo_i.no_parity |=> npb_reg && aux_reg[6]) // RL14
    else $error("missing parity not reported");

  // Summary follows the flags until they are read away
  pend_hold_a: assert property (aux_reg != 8'h00 && !rd_aux
    && !cmd_default |=> aux_pending_o) // RL15
    else $error("summary bit dropped early");

  // Reserved bits stay zero on reads
  rsvd_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) // RL16
    else $error("reserved bits not zero");

  // Every request gets exactly one ack the next cycle
  ack_time_a: assert property (req |=> ack_o ##1 !ack_o)
    else $error("bus answer timing wrong");

endmodule : aif_status

`default_nettype wire

/* File: test_aif_status.sv */
// Self-checking testbench for the auxiliary event and FIFO status block
`timescale 1ns/1ns
`default_nettype none

module test_aif_status;
  logic clk_i; // 10 MHz bench clock
  logic rst_i; // Synchronous reset, active high
  logic cyc_i; // Bus cycle
  logic stb_i; // Bus strobe
  logic we_i; // Bus write enable
  logic [7:0] adr_i; // Byte address
  logic [3:0] sel_i; // Byte selects, low lane only
  logic [31:0] dat_i; // Write data
  logic [31:0] dat_o; // Read data
  logic ack_o; // Acknowledge
  aif_pkg::aif_evt_t evt_i; // Event pulses
  aif_pkg::aif_fifo_t fifo_i; // FIFO traffic pulses
  logic aux_pending_o; // Summary bit
  logic irq_o; // Level interrupt
  int n_mismatch; // Failed comparisons
  int n_checks; // All comparisons
  logic [31:0] rd; // Word taken at the last ack

  aif_status #(.DW(32)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .evt_i(evt_i), .fifo_i(fifo_i),
    .aux_pending_o(aux_pending_o), .irq_o(irq_o)
  );

  // Free-running clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Compare a register word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_word

  // Compare a single output line
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // One classic cycle; only the watchdog ends a wait for a dead slave
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    // The answer is due one cycle after the request is taken
    chk_bit(n == 2, 1'b1, "ack latency");
  endtask : wb

  // Read one register and compare the whole word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
    input string what);
    wb(1'b0, a, 8'h00);
    chk_word(rd, exp, what);
  endtask : rdchk

  // Hold event and FIFO inputs for n cycles, then drop them
  task automatic pulse(input aif_pkg::aif_evt_t e, input aif_pkg::aif_fifo_t f,
    input int n);
    @(posedge clk_i);
    evt_i <= e;
    fifo_i <= f;
    repeat (n) @(posedge clk_i);
    evt_i <= '0;
    fifo_i <= '0;
  endtask : pulse

  // Reset contents and an unmapped read
  task automatic t_reset;
    rdchk(8'h2c, 32'h00000000, "aux reset");
    rdchk(8'h30, 32'h00000000, "count reset");
    rdchk(8'h34, 32'h00000000, "fifo2 reset");
    rdchk(8'h44, 32'h00000000, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  // Each of the seven event pulses lands on its own flag; a read clears all of them
  task automatic t_events;
    logic [31:0] exp;
    for (int i = 0; i < 7; i++)
    begin
      exp = (i < 3) ? (32'h1 << i) : (32'h1 << (i + 1));
      pulse(aif_pkg::aif_evt_t'(7'h01 << i), '0, 1);
      @(posedge clk_i);
      chk_bit(aux_pending_o, 1'b1, "summary set");
      rdchk(8'h2c, exp, "aux flag");
      rdchk(8'h2c, 32'h00000000, "aux after read");
      chk_bit(aux_pending_o, 1'b0, "summary clear");
    end
    // Writing the read-only flags must neither clear nor set them
    pulse(aif_pkg::aif_evt_t'(7'h40), '0, 1);
    wb(1'b1, 8'h2c, 8'hff);
    rdchk(8'h2c, 32'h00000080, "aux after write");
    $display("test events done");
  endtask : t_events

  // Count, partial byte, overflow, clear, underflow
  task automatic t_fifo;
    aif_pkg::aif_evt_t e;
    aif_pkg::aif_fifo_t f;
    e = '0;
    e.parity = 1'b1;
    e.crc = 1'b1;
    f = '0;
    f.push = 1'b1;
    f.bits = 3'h3;
    f.no_parity = 1'b1;
    pulse(e, f, 1);
    rdchk(8'h30, 32'h00000001, "errored byte kept");
    rdchk(8'h34, 32'h00000017, "partial byte");
    rdchk(8'h2c, 32'h00000070, "frame errors");
    f.bits = 3'h0;
    f.no_parity = 1'b0;
    pulse('0, f, 31);
    rdchk(8'h30, 32'h00000020, "full count");
    pulse('0, f, 1);
    rdchk(8'h30, 32'h00000020, "count kept");
    wb(1'b0, 8'h34, 8'h00);
    chk_word(rd & 32'h00000060, 32'h00000020, "overflow");
    rdchk(8'h2c, 32'h00000008, "overflow aux");
    wb(1'b1, 8'h40, 8'h02);
    rdchk(8'h30, 32'h00000000, "count cleared");
    rdchk(8'h34, 32'h00000000, "fifo2 cleared");
    f = '0;
    f.pop = 1'b1;
    pulse('0, f, 1);
    rdchk(8'h34, 32'h00000040, "underflow");
    rdchk(8'h2c, 32'h00000008, "underflow aux");
    f = '0;
    f.push = 1'b1;
    pulse('0, f, 2);
    f.pop = 1'b1;
    pulse('0, f, 1);
    f.push = 1'b0;
    pulse('0, f, 1);
    rdchk(8'h30, 32'h00000001, "push and pop");
    $display("test fifo done");
  endtask : t_fifo

  // Sticky status, mask and level interrupt
  task automatic t_irq;
    // Earlier tests fired every event, so all status bits are sticky
    rdchk(8'h38, 32'h000000ff, "status sticky");
    wb(1'b1, 8'h38, 8'hff);
    rdchk(8'h38, 32'h00000000, "status wiped");
    wb(1'b1, 8'h3c, 8'h80);
    pulse(aif_pkg::aif_evt_t'(7'h40), '0, 1);
    repeat (3) @(posedge clk_i);
    chk_bit(irq_o, 1'b1, "irq raised");
    wb(1'b1, 8'h3c, 8'h00);
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b0, "irq masked");
    wb(1'b1, 8'h3c, 8'h80);
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b1, "irq unmasked");
    rdchk(8'h38, 32'h00000080, "irq status");
    wb(1'b1, 8'h38, 8'h80);
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b0, "irq cleared");
    rdchk(8'h38, 32'h00000000, "status cleared");
    rdchk(8'h2c, 32'h00000080, "aux beside irq");
    $display("test irq done");
  endtask : t_irq

  // Default command empties every register
  task automatic t_default;
    aif_pkg::aif_fifo_t f;
    f = '0;
    f.push = 1'b1;
    f.bits = 3'h5;
    pulse(aif_pkg::aif_evt_t'(7'h01), f, 1);
    wb(1'b1, 8'h3c, 8'hff);
    wb(1'b1, 8'h40, 8'h01);
    rdchk(8'h2c, 32'h00000000, "aux default");
    rdchk(8'h30, 32'h00000000, "count default");
    rdchk(8'h34, 32'h00000000, "fifo2 default");
    rdchk(8'h3c, 32'h00000000, "mask default");
    $display("test default done");
  endtask : t_default

  // Print counts and verdict, then stop
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // Watchdog: the tests need well under 1000 cycles
  initial
  begin
    #500000;
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'h0;
    adr_i = 8'h00;
    sel_i = 4'h1;
    dat_i = 32'h00000000;
    evt_i = '0;
    fifo_i = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_events();
    t_fifo();
    t_irq();
    t_default();
    summarize();
  end
endmodule : test_aif_status

`default_nettype wire
